// ---- logic/dsm_accum.v ----
// first-order delta-sigma accumulator for the fractional divide word
// assumes i_step is a one-cycle pulse once per comparison cycle
`timescale 1ns/100ps
`include "fracn_defines.vh"
module dsm_accum #(
    parameter FW = 24
) (
    input wire i_clk,              // system clock
    input wire i_rst,              // sync reset, high
    input wire i_run,              // modulator running
    input wire i_step,             // comparison cycle pulse
    input wire [FW:0] i_frac,      // fractional word, up to 2^24
    output reg o_carry             // add one to divide ratio
);
    reg [FW-1:0] acc;
    wire [FW+1:0] sum;
    // carry beyond 2^FW adds one; frac of 2^FW gives carry every cycle
    assign sum = {2'b00, acc} + {1'b0, i_frac};
    always @(posedge i_clk) begin
        if (i_rst || !i_run) begin
            acc <= {FW{1'b0}};
            o_carry <= 1'b0;
        end else if (i_step) begin
            acc <= sum[FW-1:0];
            o_carry <= |sum[FW+1:FW];
        end
    end
endmodule

// ---- logic/fracn_ctrl.v ----
// fractional-n synthesizer divider control: divide words, keying, leakage
// assumes the reference pin runs well below half of i_clk so every edge is seen
// assumes write strobes are one-cycle pulses from logic on i_clk
// assumes the vco divider downstream loads o_vco_div once per comparison cycle
// Summary of operation
// - separate up and down charge-pump leakage settings create a phase offset
// - each leakage is 3 bits, linear steps, 385uA at all ones
// - vco equals pfd times integer word plus pfd times frac over 2^24
// - integer divide ratio accepted only from 36 to 65535
// - integer word held as 16 bits, fractional word as 24 bits
// - comparison rate is reference divided by the reference ratio
// - fractional mode only when modulator and buffer enables both set
// - fractional and seed words accept 1 to 2^24
// - keying enabled and serial enable low: data pin selects frequency
// - serial enable high stops keying, returns to base frequency
// - data 0 uses frac word, data 1 uses frac plus seed, clamped at 2^24
// - keying data sampled on falling edge of divided reference
// - keyed frequency change is an abrupt unshaped step
// - integer mode steps equal the comparison frequency only
// - integer mode: modulator off, divide ratio fixed
// - divide words not double buffered, take effect on write
`timescale 1ns/100ps
`include "fracn_defines.vh"
module fracn_ctrl #(
    parameter IW = `INT_W,
    parameter FW = `FRAC_W,
    parameter LW = `LEAK_W,
    parameter RW = `RDIV_W
) (
    input wire i_clk,                    // 40 mhz system clock
    input wire i_rst,                    // sync reset, high
    input wire i_ref_clk_pin,            // reference oscillator input pin
    input wire [RW-1:0] i_rdiv,          // reference division ratio
    input wire i_int_we,                 // write strobe, integer word
    input wire [IW-1:0] i_int_word,      // integer divide word
    input wire i_frac_we,                // write strobe, fractional word
    input wire [FW-1:0] i_frac_word,     // fractional word
    input wire i_seed_we,                // write strobe, seed word
    input wire [FW-1:0] i_seed_word,     // seed word
    input wire i_mod_run,                // modulator-run enable
    input wire i_buf_run,                // divider-buffer-run enable
    input wire i_fsk_enable,             // keying enable
    input wire i_serial_enable_pin,      // serial enable pin
    input wire i_serial_data_in_pin,     // serial data pin
    input wire [LW-1:0] i_up_leak_sel,   // up pump leakage code
    input wire [LW-1:0] i_down_leak_sel, // down pump leakage code
    output reg o_pfd_clk,                // divided reference, comparison rate
    output reg [IW:0] o_vco_div,         // instantaneous vco divide ratio
    output reg o_frac_mode,              // fractional mode active
    output reg o_int_err,                // last integer write out of range
    output reg o_keying,                 // keying active
    output reg o_key_bit,                // sampled keying bit
    output reg [8:0] o_up_leak_na,       // up leakage in units of 1uA
    output reg [8:0] o_down_leak_na      // down leakage in units of 1uA
);
    reg ref_s1, ref_s2, ref_d, sen_s1, sen_s2, sdi_s1, sdi_s2;
    reg [RW-1:0] rcnt;
    reg pfd_d;
    reg [IW-1:0] int_word;
    reg [FW-1:0] frac_word, seed_word;
    wire ref_rise, pfd_fall, pfd_rise, frac_on, carry;
    wire [FW:0] eff_frac;
    wire [FW+1:0] key_sum;

    // leakage in uA: equal steps from the code
    function [8:0] leak_ua;
        input [LW-1:0] code;
        leak_ua = code * `LEAK_STEP_NA;
    endfunction

    // a zero word stands for 2^24, so the top bit flags it
    function [FW:0] full_word;
        input [FW-1:0] word;
        full_word = {(word == {FW{1'b0}}), word};
    endfunction

    // pins pass two flops before any logic reads them
    always @(posedge i_clk) begin
        ref_s1 <= i_ref_clk_pin;
        ref_s2 <= ref_s1;
        sen_s1 <= i_serial_enable_pin;
        sen_s2 <= sen_s1;
        sdi_s1 <= i_serial_data_in_pin;
        sdi_s2 <= sdi_s1;
    end
    // ref_d resets low, so a reference already high at release gives one harmless early edge
    assign ref_rise = ref_s2 && !ref_d;

    // reference divider; ratio 0 or 1 passes the reference straight through
    always @(posedge i_clk) begin
        if (i_rst) begin
            ref_d <= 1'b0;
            rcnt <= {RW{1'b0}};
            o_pfd_clk <= 1'b0;
        end else begin
            ref_d <= ref_s2;
            if (i_rdiv <= `RDIV_RST) begin
                // divide by one: comparison edges follow every reference edge
                rcnt <= {RW{1'b0}};
                o_pfd_clk <= ref_s2;
            end else if (ref_rise) begin
                // high from the wrap, low once the count reaches half the ratio
                if (rcnt + 1'b1 >= i_rdiv) begin
                    rcnt <= {RW{1'b0}};
                    o_pfd_clk <= 1'b1;
                end else begin
                    rcnt <= rcnt + 1'b1;
                    if (rcnt + 1'b1 >= (i_rdiv >> 1))
                        o_pfd_clk <= 1'b0;
                end
            end
        end
    end
    // delayed copy for edge pulses; both reset low so no false edge follows reset
    always @(posedge i_clk) begin
        if (i_rst)
            pfd_d <= 1'b0;
        else
            pfd_d <= o_pfd_clk;
    end
    assign pfd_fall = pfd_d && !o_pfd_clk;
    assign pfd_rise = o_pfd_clk && !pfd_d;

    // divide words, no double buffering: live the cycle after the strobe
    // no shadow copy: a write moves the ratio at once, so the loop must ride out the step
    always @(posedge i_clk) begin
        if (i_rst) begin
            int_word <= `INT_RST;
            frac_word <= `FRAC_RST;
            seed_word <= `FRAC_RST;
            o_int_err <= 1'b0;
        end else begin
            if (i_int_we) begin
                // out-of-range ratios refused, word kept
                if ({1'b0, i_int_word} >= `INT_MIN && {1'b0, i_int_word} <= `INT_MAX) begin
                    int_word <= i_int_word;
                    o_int_err <= 1'b0;
                end else
                    o_int_err <= 1'b1;
            end
            if (i_frac_we)
                frac_word <= i_frac_word;
            if (i_seed_we)
                seed_word <= i_seed_word;
        end
    end

    // fractional mode needs both enables; else modulator off
    // one enable alone stays in integer mode, so a half-done mode change is harmless
    assign frac_on = i_mod_run && i_buf_run;

    // keying: sample on falling pfd edge, stop when serial enable high
    // the bit clears with the enable, so a stale one never shifts the base frequency
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_keying <= 1'b0;
            o_key_bit <= 1'b0;
        end else begin
            o_keying <= i_fsk_enable && !sen_s2;
            if (!i_fsk_enable || sen_s2)
                o_key_bit <= 1'b0;
            else if (pfd_fall)
                o_key_bit <= sdi_s2;
        end
    end

    // zero word means 2^24; data 1 adds seed, abrupt step
    assign key_sum = {1'b0, full_word(frac_word)} +
                     (o_key_bit ? {1'b0, full_word(seed_word)} : {(FW+2){1'b0}});
    // first-order modulator carries at most one per cycle, so sums past 2^24 clamp there
    assign eff_frac = (key_sum[FW+1:FW] != 2'h0) ? {1'b1, {FW{1'b0}}} : key_sum[FW:0];

    dsm_accum #(.FW(FW)) u_dsm (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(frac_on),
        .i_step(pfd_rise),
        .i_frac(eff_frac),
        .o_carry(carry)
    );

    // per-cycle divide ratio averages int + frac/2^24 integer mode fixed
    // one cycle behind the carry; the downstream divider loads it at its next comparison edge
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_vco_div <= {1'b0, `INT_RST};
            o_frac_mode <= 1'b0;
        end else begin
            o_frac_mode <= frac_on;
            o_vco_div <= {1'b0, int_word} + {{IW{1'b0}}, (frac_on && carry)};
        end
    end

    // leakage linear, 55uA step, 385uA at all ones
    // registered so the pumps see one clean code change, never a half-updated field
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_up_leak_na <= leak_ua(`LEAK_RST);
            o_down_leak_na <= leak_ua(`LEAK_RST);
        end else begin
            o_up_leak_na <= leak_ua(i_up_leak_sel);
            o_down_leak_na <= leak_ua(i_down_leak_sel);
        end
    end
endmodule

// ---- shared/fracn_defines.vh ----
// constants for the fractional-n divider control block
// included by the design files; definitions only
`ifndef FRACN_DEFINES_VH
`define FRACN_DEFINES_VH
`define INT_W 16
`define FRAC_W 24
`define LEAK_W 3
`define RDIV_W 14
`define INT_MIN 17'h0_0024
`define INT_MAX 17'h1_001F
`define INT_RST 16'h002E
`define FRAC_RST 24'h00_0001
`define RDIV_RST 14'h0001
`define LEAK_RST 3'h0
`define LEAK_STEP_NA 9'h037
`endif

// ---- verif/fracn_ctrl_bench.sv ----
// self-checking bench for fracn_ctrl with a host pin model
// assumes the checker and host model are compiled first
`timescale 1ns/100ps
module fracn_ctrl_bench;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg we = 1'b0, fwe = 1'b0, swe = 1'b0, mod = 1'b0, buff = 1'b0, fsk = 1'b0, go = 1'b0, bit_v = 1'b0;
    reg [1:0] ref_cnt = 2'h0;
    reg [15:0] iw = 16'h002E;
    reg [23:0] fw = 24'h00_0001, sw = 24'h00_0001;
    reg [2:0] up = 3'h0, dn = 3'h0;
    reg [13:0] rd = 14'h0002;
    wire serial_enable_pin, serial_data_in_pin, pfd, frm, err, key, kb;
    wire [16:0] div;
    wire [8:0] upn, dnn;
    integer num_errors = 0, compares = 0, hits, rises, i;
    always #12.5 i_clk = ~i_clk;
    // reference pin at a quarter of the clock, so pfd spans eight clocks
    always @(posedge i_clk) ref_cnt <= ref_cnt + 2'h1;
    host_model host_model_i (.i_clk(i_clk), .i_go(go), .i_bit(bit_v), .o_sen(serial_enable_pin), .o_sdi(serial_data_in_pin));
    fracn_ctrl fracn_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_ref_clk_pin(ref_cnt[1]), .i_rdiv(rd),
        .i_int_we(we), .i_int_word(iw), .i_frac_we(fwe), .i_frac_word(fw), .i_seed_we(swe), .i_seed_word(sw),
        .i_mod_run(mod), .i_buf_run(buff), .i_fsk_enable(fsk), .i_serial_enable_pin(serial_enable_pin),
        .i_serial_data_in_pin(serial_data_in_pin), .i_up_leak_sel(up), .i_down_leak_sel(dn), .o_pfd_clk(pfd), .o_vco_div(div),
        .o_frac_mode(frm), .o_int_err(err), .o_keying(key), .o_key_bit(kb), .o_up_leak_na(upn),
        .o_down_leak_na(dnn));
    task chk(input [16:0] got, input [16:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD t=%0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    // counts settled cycles showing ratio v and rising pfd edges; ends at a falling edge
    task watch(input integer n, input [16:0] v);
        reg pfd_prev;
        begin
            hits = 0;
            rises = 0;
            pfd_prev = 1'b1;
            repeat (n) begin
                @(negedge i_clk);
                if (div === v) hits = hits + 1;
                if (pfd === 1'b1 && pfd_prev === 1'b0) rises = rises + 1;
                pfd_prev = pfd;
            end
        end
    endtask
    // one integer write; ratio shows two edges after it is taken
    task wr_int(input [15:0] w, input e, input [16:0] d);
        begin
            tick(1);
            iw <= w;
            we <= 1'b1;
            tick(1);
            we <= 1'b0;
            tick(1);
            @(negedge i_clk);
            chk({16'h0000, err}, {16'h0000, e});
            chk(div, d);
        end
    endtask
    task report_and_stop;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // watchdog well past the expected run of about six hundred clocks
    initial begin
        tick(5000);
        num_errors = num_errors + 1;
        report_and_stop;
    end
    initial begin
        tick(12);
        i_rst <= 1'b0;
        tick(1);
        @(negedge i_clk);
        chk(div, 17'h0_002E);
        for (i = 0; i < 8; i = i + 1) begin
            tick(1);
            up <= i[2:0];
            dn <= 3'h7 - i[2:0];
            tick(2);
            @(negedge i_clk);
            chk({8'h00, upn}, i * 17'h0_0037);
            chk({8'h00, dnn}, (7 - i) * 17'h0_0037);
        end
        $display("leakage steps done");
        wr_int(16'h0064, 1'b0, 17'h0_0064);
        wr_int(16'h0023, 1'b1, 17'h0_0064);
        wr_int(16'hFFFF, 1'b0, 17'h0_FFFF);
        wr_int(16'h0024, 1'b0, 17'h0_0024);
        $display("integer writes done");
        tick(1);
        fw <= 24'h80_0000;
        sw <= 24'hFF_FFFF;
        fwe <= 1'b1;
        swe <= 1'b1;
        mod <= 1'b1;
        tick(1);
        fwe <= 1'b0;
        swe <= 1'b0;
        watch(80, 17'h0_0025);
        chk(hits, 0);
        chk(rises >= 9 && rises <= 10, 17'h0_0001);
        tick(1);
        buff <= 1'b1; // buffer enable set; modulator enable already on, so both set
        watch(80, 17'h0_0025);
        chk({16'h0000, frm}, 17'h0_0001);
        chk(hits >= 30 && hits <= 42, 17'h0_0001);
        // tiny frac word with full seed: carry only when the bit is one
        tick(1);
        fw <= 24'h00_0001;
        fwe <= 1'b1;
        fsk <= 1'b1;
        go <= 1'b1;
        tick(1);
        fwe <= 1'b0;
        tick(16);
        watch(80, 17'h0_0025);
        chk(hits, 0);
        chk({key, kb}, 17'h0_0002);
        tick(1);
        bit_v <= 1'b1;
        tick(16);
        watch(80, 17'h0_0025);
        chk({16'h0000, kb}, 17'h0_0001);
        chk(hits >= 70, 17'h0_0001);
        tick(1);
        go <= 1'b0;
        tick(8);
        @(negedge i_clk);
        chk({key, kb}, 17'h0_0000);
        tick(8);
        watch(80, 17'h0_0025);
        chk(hits, 0);
        // divide by one: comparison edges at the full reference rate
        tick(1);
        rd <= 14'h0001;
        tick(4);
        watch(80, 17'h0_0024);
        chk(hits, 80);
        chk(rises >= 19 && rises <= 20, 17'h0_0001);
        $display("frac and keying done");
        report_and_stop;
    end
endmodule
bind fracn_ctrl fracn_ctrl_sva fracn_ctrl_sva_i (.i_clk(i_clk), .i_rst(i_rst), .i_int_we(i_int_we),
    .i_int_word(i_int_word), .i_mod_run(i_mod_run), .i_buf_run(i_buf_run), .i_fsk_enable(i_fsk_enable),
    .i_serial_enable_pin(i_serial_enable_pin), .i_up_leak_sel(i_up_leak_sel), .o_pfd_clk(o_pfd_clk),
    .o_vco_div(o_vco_div), .o_frac_mode(o_frac_mode), .o_int_err(o_int_err), .o_keying(o_keying),
    .o_key_bit(o_key_bit), .o_up_leak_na(o_up_leak_na));

// ---- verif/fracn_ctrl_sva.sv ----
// port checker for fracn_ctrl
// bound from the bench top; one clock domain
`timescale 1ns/100ps
module fracn_ctrl_sva (
    input wire i_clk, // clock
    input wire i_rst, // reset
    input wire i_int_we, // int strobe
    input wire [15:0] i_int_word, // int word
    input wire i_mod_run, // mod enable
    input wire i_buf_run, // buf enable
    input wire i_fsk_enable, // keying enable
    input wire i_serial_enable_pin, // sen
    input wire [2:0] i_up_leak_sel, // up code
    input wire o_pfd_clk, // pfd clock
    input wire [16:0] o_vco_div, // ratio
    input wire o_frac_mode, // frac flag
    input wire o_int_err, // refusal
    input wire o_keying, // keying
    input wire o_key_bit, // key bit
    input wire [8:0] o_up_leak_na // up leakage
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // leakage tracks the code in equal steps
    a_up_leak_scale: assert property ($stable(i_up_leak_sel) |-> o_up_leak_na == i_up_leak_sel * 9'h037)
        else $error("up leakage off scale");
    a_frac_on_both: assert property (i_mod_run && i_buf_run |=> o_frac_mode)
        else $error("frac mode missing");
    // six quiet cycles let any carry in flight drain first
    a_int_mode_hold: assert property ((!i_mod_run && !i_buf_run && !i_int_we)[*6] |->
        !o_frac_mode && $stable(o_vco_div)) else $error("integer ratio moved");
    a_int_write_live: assert property (i_int_we && i_int_word == 16'h0064 && !o_frac_mode |->
        ##2 o_vco_div == 17'h0_0064) else $error("int write late");
    a_int_low_refused: assert property (i_int_we && i_int_word < 16'h0024 |=> o_int_err)
        else $error("low ratio taken");
    a_key_on_low: assert property ((i_fsk_enable && !i_serial_enable_pin)[*4] |-> o_keying)
        else $error("keying not on");
    a_key_off_high: assert property (i_serial_enable_pin[*4] |-> !o_keying && !o_key_bit)
        else $error("keying not off");
    // a keyed bit only lands once the divided reference has fallen
    a_key_at_fall: assert property (o_keying && $past(o_keying) && $changed(o_key_bit) |->
        !$past(o_pfd_clk) && $past(o_pfd_clk, 2)) else $error("key bit off the fall");
    c_keying: cover property (o_keying && o_key_bit);
    c_frac: cover property (o_frac_mode && o_vco_div == 17'h0_0025);
    c_refused: cover property (o_int_err);
endmodule

// ---- verif/host_model.sv ----
// host controller model for the serial pins while keying
// assumes the bench raises i_go for a keying window
`timescale 1ns/100ps
module host_model (
    input wire i_clk, // clock
    input wire i_go, // keying window
    input wire i_bit, // symbol
    output reg o_sen = 1'b1, // serial enable pin
    output reg o_sdi = 1'b0 // serial data pin
);
    // sen low only in a window; no serial clock exists to move
    // outside a window data wanders so a stale level never passes
    always @(posedge i_clk) begin
        o_sen <= !i_go;
        o_sdi <= i_go ? i_bit : !o_sdi;
    end
endmodule
